// File: hdl/pmx_pkg.sv
// Package with register offsets, reset values and bit masks of the port mux.
package pmx_pkg;
  localparam int PMX_ADDR_W = 8;
  localparam int PMX_PORT_W = 8;
  localparam logic [7:0] PMX_P1_BASE = 8'h00;
  localparam logic [7:0] PMX_P2_BASE = 8'h20;
  localparam logic [7:0] PMX_P3_BASE = 8'h40;
  localparam logic [4:0] PMX_OFS_INPUT = 5'h00;
  localparam logic [4:0] PMX_OFS_OUTPUT = 5'h04;
  localparam logic [4:0] PMX_OFS_DIRECTION = 5'h08;
  localparam logic [4:0] PMX_OFS_IRQ_FLAG = 5'h0c;
  localparam logic [4:0] PMX_OFS_IRQ_EDGE = 5'h10;
  localparam logic [4:0] PMX_OFS_IRQ_ENABLE = 5'h14;
  localparam logic [4:0] PMX_OFS_FUNC_SEL = 5'h18;
  localparam logic [7:0] PMX_RST_VAL = 8'h00;
  localparam logic [7:0] PMX_P2_BONDED = 8'h3f;
  localparam logic [7:0] PMX_ALL_BONDED = 8'hff;
  localparam logic [1:0] PMX_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMX_RESP_SLVERR = 2'h2;
endpackage

// File: hdl/pmx_pin_cell.sv
// Output and direction multiplexing for one eight-bit port.
`timescale 1ns/1ps
module pmx_pin_cell #(
  parameter int WIDTH = 8,
  parameter logic [7:0] BONDED = 8'hff
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] funcSel,
  input wire logic [WIDTH-1:0] dirReg,
  input wire logic [WIDTH-1:0] outReg,
  input wire logic [WIDTH-1:0] periphOut,
  input wire logic [WIDTH-1:0] periphDir,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut,
  output logic [WIDTH-1:0] pinOe,
  output logic [WIDTH-1:0] pinLevel
);
  import pmx_pkg::*;

  if (WIDTH != 8) begin : g_bad_width
    $error("pmx_pin_cell serves eight-bit ports only");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        pinOut[i] <= 1'b0;
        pinOe[i] <= 1'b0;
        pinLevel[i] <= 1'b0;
      end else begin
        // Unbonded bits never drive and read back the output latch.
        pinOut[i] <= BONDED[i] & (funcSel[i] ? periphOut[i] : outReg[i]);
        pinOe[i] <= BONDED[i] & (funcSel[i] ? periphDir[i] : dirReg[i]);
        pinLevel[i] <= BONDED[i] ? pinIn[i] : 1'b0;
      end
    end
  end
endmodule

// File: hdl/pmx_irq_port.sv
// Edge-triggered interrupt flags, edge selects and enables of one port.
`timescale 1ns/1ps
module pmx_irq_port #(
  parameter int WIDTH = 8,
  parameter logic [7:0] HW_SET = 8'hff
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinLevel,
  input wire logic flagWr,
  input wire logic edgeWr,
  input wire logic enableWr,
  input wire logic [WIDTH-1:0] wrData,
  output logic [WIDTH-1:0] flagReg,
  output logic [WIDTH-1:0] edgeReg,
  output logic [WIDTH-1:0] enableReg,
  output logic irqReq
);
  import pmx_pkg::*;

  logic [WIDTH-1:0] prevLevel;
  logic [WIDTH-1:0] edgeHit;
  logic [1:0] warmUp;

  if (WIDTH != 8) begin : g_bad_width
    $error("pmx_irq_port serves eight-bit ports only");
  end

  // Each bit's edge select clear means rising edge, set means falling edge.
  // Edges wait two cycles after reset, so a pin that is already high then
  // is not mistaken for a rising edge.
  assign edgeHit = {WIDTH{warmUp[1]}} & HW_SET
                   & ((edgeReg & prevLevel & ~pinLevel)
                      | (~edgeReg & ~prevLevel & pinLevel));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prevLevel <= PMX_RST_VAL;
      warmUp <= 2'h0;
    end else begin
      prevLevel <= pinLevel;
      warmUp <= {warmUp[0], 1'b1};
    end
  end

  // A pin event in the cycle of a software write still sets the flag.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flagReg <= PMX_RST_VAL;
    end else begin
      flagReg <= (flagWr ? wrData : flagReg) | edgeHit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      edgeReg <= PMX_RST_VAL;
      enableReg <= PMX_RST_VAL;
    end else begin
      if (edgeWr) begin
        edgeReg <= wrData;
      end
      if (enableWr) begin
        enableReg <= wrData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= |(flagReg & enableReg);
    end
  end
endmodule

// File: hdl/pmx_port_mux.sv
// Top of the three-port pin function multiplexer with its register slave.
`timescale 1ns/1ps
module pmx_port_mux (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [pmx_pkg::PMX_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmx_pkg::PMX_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] port1PinIn,
  output logic [7:0] port1PinOut,
  output logic [7:0] port1PinOe,
  input wire logic [7:0] port2PinIn,
  output logic [7:0] port2PinOut,
  output logic [7:0] port2PinOe,
  input wire logic [7:0] port3PinIn,
  output logic [7:0] port3PinOut,
  output logic [7:0] port3PinOe,
  output logic port1IrqReq,
  output logic port2IrqReq,
  input wire logic timerOut0,
  input wire logic timerOut1,
  input wire logic timerOut2,
  input wire logic subMainClockOut,
  input wire logic auxClockOut,
  input wire logic comparatorResultOut,
  input wire logic serialTransmitOut,
  input wire logic serialShiftClockOut,
  input wire logic serialBit1Out,
  input wire logic serialBit1Oe,
  input wire logic serialBit2Out,
  input wire logic serialBit2Oe,
  input wire logic serialAsyncMode,
  input wire logic serialMasterMode,
  output logic timerClockIn,
  output logic timerAltClockIn,
  output logic timerCapture0InA,
  output logic timerCapture1InA,
  output logic timerCapture2InA,
  output logic timerCapture0InB,
  output logic serialReceiveIn,
  output logic serialSlaveEnableIn,
  output logic serialShiftClockIn,
  output logic serialBit1In,
  output logic serialBit2In
);
  import pmx_pkg::*;

  logic [2:0][7:0] outReg;
  logic [2:0][7:0] dirReg;
  logic [2:0][7:0] selReg;
  logic [2:0][7:0] pinLevel;
  logic [2:0][7:0] periphOut;
  logic [2:0][7:0] periphDir;
  logic [1:0][7:0] flagReg;
  logic [1:0][7:0] edgeReg;
  logic [1:0][7:0] enableReg;
  logic [1:0] flagWr;
  logic [1:0] edgeWr;
  logic [1:0] enableWr;
  logic [7:0] awAddrReg;
  logic [7:0] wDataReg;
  logic [3:0] wStrbReg;
  logic awHeld;
  logic wHeld;
  logic wrFire;
  logic [1:0] wrPort;
  logic [4:0] wrOfs;
  logic wrHit;
  logic [1:0] rdPort;
  logic [4:0] rdOfs;
  logic [7:0] rdData;
  logic rdHit;

  // Peripheral outputs per bit; unbonded and unused bits stay low.
  always_comb begin
    periphOut[0] = {timerOut2, timerOut1, timerOut0, subMainClockOut,
                    timerOut2, timerOut1, timerOut0, 1'b0};
    periphOut[1] = {3'h0, timerOut2, timerOut1, comparatorResultOut, 1'b0,
                    auxClockOut};
    periphOut[2] = {3'h0, serialTransmitOut, serialShiftClockOut,
                    serialBit2Out, serialBit1Out, 1'b0};
    periphDir[0] = dirReg[0];
    periphDir[1] = dirReg[1];
    // The shift clock pin drives only in synchronous master mode.
    periphDir[2] = {3'h0, 1'b1, ~serialAsyncMode & serialMasterMode,
                    serialBit2Oe, serialBit1Oe, 1'b0};
  end

  pmx_pin_cell #(.WIDTH(PMX_PORT_W), .BONDED(PMX_ALL_BONDED)) u_cell1 (
    .ref_clk(ref_clk), .rst(rst), .funcSel(selReg[0]), .dirReg(dirReg[0]),
    .outReg(outReg[0]), .periphOut(periphOut[0]), .periphDir(periphDir[0]),
    .pinIn(port1PinIn), .pinOut(port1PinOut), .pinOe(port1PinOe),
    .pinLevel(pinLevel[0])
  );

  pmx_pin_cell #(.WIDTH(PMX_PORT_W), .BONDED(PMX_P2_BONDED)) u_cell2 (
    .ref_clk(ref_clk), .rst(rst), .funcSel(selReg[1]), .dirReg(dirReg[1]),
    .outReg(outReg[1]), .periphOut(periphOut[1]), .periphDir(periphDir[1]),
    .pinIn(port2PinIn), .pinOut(port2PinOut), .pinOe(port2PinOe),
    .pinLevel(pinLevel[1])
  );

  pmx_pin_cell #(.WIDTH(PMX_PORT_W), .BONDED(PMX_ALL_BONDED)) u_cell3 (
    .ref_clk(ref_clk), .rst(rst), .funcSel(selReg[2]), .dirReg(dirReg[2]),
    .outReg(outReg[2]), .periphOut(periphOut[2]), .periphDir(periphDir[2]),
    .pinIn(port3PinIn), .pinOut(port3PinOut), .pinOe(port3PinOe),
    .pinLevel(pinLevel[2])
  );

  // Pin events cannot reach the unbonded port two flags.
  pmx_irq_port #(.WIDTH(PMX_PORT_W), .HW_SET(PMX_ALL_BONDED)) u_irq1 (
    .ref_clk(ref_clk), .rst(rst), .pinLevel(pinLevel[0]),
    .flagWr(flagWr[0]), .edgeWr(edgeWr[0]), .enableWr(enableWr[0]),
    .wrData(wDataReg), .flagReg(flagReg[0]), .edgeReg(edgeReg[0]),
    .enableReg(enableReg[0]), .irqReq(port1IrqReq)
  );

  pmx_irq_port #(.WIDTH(PMX_PORT_W), .HW_SET(PMX_P2_BONDED)) u_irq2 (
    .ref_clk(ref_clk), .rst(rst), .pinLevel(pinLevel[1]),
    .flagWr(flagWr[1]), .edgeWr(edgeWr[1]), .enableWr(enableWr[1]),
    .wrData(wDataReg), .flagReg(flagReg[1]), .edgeReg(edgeReg[1]),
    .enableReg(enableReg[1]), .irqReq(port2IrqReq)
  );

  // Peripheral inputs see the pin only while the function is selected.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      timerClockIn <= 1'b0;
      timerCapture0InA <= 1'b0;
      timerCapture1InA <= 1'b0;
      timerCapture2InA <= 1'b0;
      timerAltClockIn <= 1'b0;
      timerCapture0InB <= 1'b0;
    end else begin
      timerClockIn <= selReg[0][0] & port1PinIn[0];
      timerCapture0InA <= selReg[0][1] & port1PinIn[1];
      timerCapture1InA <= selReg[0][2] & port1PinIn[2];
      timerCapture2InA <= selReg[0][3] & port1PinIn[3];
      timerAltClockIn <= selReg[1][1] & port2PinIn[1];
      timerCapture0InB <= selReg[1][2] & port2PinIn[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      serialSlaveEnableIn <= 1'b0;
      serialBit1In <= 1'b0;
      serialBit2In <= 1'b0;
      serialShiftClockIn <= 1'b0;
      serialReceiveIn <= 1'b0;
    end else begin
      serialSlaveEnableIn <= selReg[2][0] & port3PinIn[0];
      serialBit1In <= selReg[2][1] & port3PinIn[1];
      serialBit2In <= selReg[2][2] & port3PinIn[2];
      // In synchronous master mode the module uses its own clock, not the pin.
      serialShiftClockIn <= selReg[2][3] & port3PinIn[3]
                            & (serialAsyncMode | ~serialMasterMode);
      serialReceiveIn <= selReg[2][5] & port3PinIn[5];
    end
  end

  // Address and data are taken in either order and held until both are in.
  assign wrFire = awHeld & wHeld & ~s_axi_bvalid;
  assign wrPort = awAddrReg[6:5];
  assign wrOfs = awAddrReg[4:0];
  assign wrHit = (wrPort != 2'h3) & (wrOfs[1:0] == 2'h0)
                 & (wrOfs <= PMX_OFS_FUNC_SEL)
                 & ((wrPort != 2'h2) | (wrOfs == PMX_OFS_INPUT)
                    | (wrOfs == PMX_OFS_OUTPUT) | (wrOfs == PMX_OFS_DIRECTION)
                    | (wrOfs == PMX_OFS_FUNC_SEL));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrReg <= 8'h00;
      wDataReg <= 8'h00;
      wStrbReg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= ~awHeld & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~wHeld & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrReg <= s_axi_awaddr;
      end else if (wrFire) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld <= 1'b1;
        wDataReg <= s_axi_wdata[7:0];
        wStrbReg <= s_axi_wstrb;
      end else if (wrFire) begin
        wHeld <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PMX_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // The input registers are read-only; a write to them is accepted silently.
  for (genvar p = 0; p < 3; p++) begin : g_ctl
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        outReg[p] <= PMX_RST_VAL;
        dirReg[p] <= PMX_RST_VAL;
        selReg[p] <= PMX_RST_VAL;
      end else if (wrFire & wrHit & wStrbReg[0] & (wrPort == p)) begin
        if (wrOfs == PMX_OFS_OUTPUT) begin
          outReg[p] <= wDataReg;
        end
        if (wrOfs == PMX_OFS_DIRECTION) begin
          dirReg[p] <= wDataReg;
        end
        if (wrOfs == PMX_OFS_FUNC_SEL) begin
          selReg[p] <= wDataReg;
        end
      end
    end
  end

  for (genvar q = 0; q < 2; q++) begin : g_irqwr
    always_comb begin
      flagWr[q] = wrFire & wrHit & wStrbReg[0] & (wrPort == q)
                  & (wrOfs == PMX_OFS_IRQ_FLAG);
      edgeWr[q] = wrFire & wrHit & wStrbReg[0] & (wrPort == q)
                  & (wrOfs == PMX_OFS_IRQ_EDGE);
      enableWr[q] = wrFire & wrHit & wStrbReg[0] & (wrPort == q)
                    & (wrOfs == PMX_OFS_IRQ_ENABLE);
    end
  end

  assign rdPort = s_axi_araddr[6:5];
  assign rdOfs = s_axi_araddr[4:0];

  always_comb begin
    rdData = 8'h00;
    rdHit = 1'b0;
    if ((rdPort != 2'h3) & (rdOfs[1:0] == 2'h0)) begin
      rdHit = 1'b1;
      case (rdOfs)
        PMX_OFS_INPUT: rdData = (rdPort == 2'h1) ? (pinLevel[1] | (outReg[1]
                                & ~PMX_P2_BONDED)) : pinLevel[rdPort];
        PMX_OFS_OUTPUT: rdData = outReg[rdPort];
        PMX_OFS_DIRECTION: rdData = dirReg[rdPort];
        PMX_OFS_FUNC_SEL: rdData = selReg[rdPort];
        PMX_OFS_IRQ_FLAG: rdData = (rdPort == 2'h2) ? 8'h00 : flagReg[rdPort[0]];
        PMX_OFS_IRQ_EDGE: rdData = (rdPort == 2'h2) ? 8'h00 : edgeReg[rdPort[0]];
        PMX_OFS_IRQ_ENABLE: rdData = (rdPort == 2'h2) ? 8'h00
                                     : enableReg[rdPort[0]];
        default: rdHit = 1'b0;
      endcase
      if ((rdPort == 2'h2) & (rdOfs > PMX_OFS_DIRECTION)
          & (rdOfs != PMX_OFS_FUNC_SEL)) begin
        rdHit = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= PMX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rdHit ? rdData : 8'h00};
        s_axi_rresp <= rdHit ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: tb/pmx_pin_model.sv
// Board model: outside drivers sitting behind all twenty-four port pins.
`timescale 1ns/1ps
module pmx_pin_model #(
  parameter int WIDTH = 24
) (
  input wire logic [WIDTH-1:0] pinOut,
  input wire logic [WIDTH-1:0] pinOe,
  input wire logic [WIDTH-1:0] extVal,
  output logic [WIDTH-1:0] pinIn
);
  // A driven pin reads back its own level, otherwise the board wins.
  // This is how an outside master hands in the shift clock.
  assign pinIn = (pinOe & pinOut) | (~pinOe & extVal);
endmodule

// File: tb/pmx_port_mux_chk.sv
// Checker with port-level properties of the pin multiplexer.
`timescale 1ns/1ps
module pmx_port_mux_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] port1PinIn,
  input wire logic [7:0] port2PinIn,
  input wire logic [7:0] port3PinIn,
  input wire logic [7:0] port2PinOut,
  input wire logic [7:0] port2PinOe,
  input wire logic [7:0] port3PinOe,
  input wire logic port1IrqReq,
  input wire logic port2IrqReq,
  input wire logic timerClockIn,
  input wire logic serialReceiveIn,
  input wire logic serialSlaveEnableIn,
  input wire logic serialShiftClockIn,
  input wire logic serialAsyncMode,
  input wire logic serialMasterMode
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_unbond;
    (port2PinOe[7:6] | port2PinOut[7:6]) == 2'h0;
  endproperty
  a_unbond: assert property (p_unbond) else $error("unbonded driven");
  property p_tclk;
    timerClockIn |-> $past(port1PinIn[0]);
  endproperty
  a_tclk: assert property (p_tclk) else $error("timer clock");
  property p_rx;
    serialReceiveIn |-> $past(port3PinIn[5]) && !port3PinOe[5];
  endproperty
  a_rx: assert property (p_rx) else $error("receive path");
  property p_ste;
    serialSlaveEnableIn |-> $past(port3PinIn[0]) && !port3PinOe[0];
  endproperty
  a_ste: assert property (p_ste) else $error("slave enable");
  property p_slv;
    serialShiftClockIn |-> $past(port3PinIn[3])
      && !$past(serialMasterMode && !serialAsyncMode);
  endproperty
  a_slv: assert property (p_slv) else $error("slave clock");
  property p_async;
    serialShiftClockIn && $past(serialAsyncMode) |-> !port3PinOe[3];
  endproperty
  a_async: assert property (p_async) else $error("async clock");
  // A flag rises two edges after the pin, the request one edge later.
  property p_irq1;
    $rose(port1IrqReq) |-> $past(s_axi_bvalid)
      || $past(port1PinIn, 3) != $past(port1PinIn, 4);
  endproperty
  a_irq1: assert property (p_irq1) else $error("irq1 cause");
  property p_irq2;
    $rose(port2IrqReq) |-> $past(s_axi_bvalid)
      || $past(port2PinIn[5:0], 3) != $past(port2PinIn[5:0], 4);
  endproperty
  a_irq2: assert property (p_irq2) else $error("irq2 cause");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  c_irq1: cover property ($rose(port1IrqReq));
  c_irq2: cover property ($rose(port2IrqReq));
  c_sclk: cover property (serialShiftClockIn);
endmodule
bind pmx_port_mux pmx_port_mux_chk pmx_port_mux_chk_inst (.*);

// File: tb/pmx_port_mux_tb.sv
// Self-checking bench of the three-port pin multiplexer.
`timescale 1ns/1ps
module pmx_port_mux_tb;
  import pmx_pkg::*;
  logic ref_clk, rst, port1IrqReq, port2IrqReq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] port1PinIn, port1PinOut, port1PinOe, port2PinIn, port2PinOut;
  logic [7:0] port2PinOe, port3PinIn, port3PinOut, port3PinOe;
  logic timerOut0, timerOut1, timerOut2, subMainClockOut, auxClockOut;
  logic comparatorResultOut, serialTransmitOut, serialShiftClockOut;
  logic serialBit1Out, serialBit1Oe, serialBit2Out, serialBit2Oe;
  logic serialAsyncMode, serialMasterMode, timerClockIn, timerAltClockIn;
  logic timerCapture0InA, timerCapture1InA, timerCapture2InA;
  logic timerCapture0InB, serialReceiveIn, serialSlaveEnableIn;
  logic serialShiftClockIn, serialBit1In, serialBit2In;
  logic [9:0] per;
  logic [23:0] ext;
  int fails, check_count, cyc;
  assign {serialShiftClockOut, serialTransmitOut, serialBit1Oe, serialBit1Out,
    comparatorResultOut, auxClockOut, subMainClockOut, timerOut2, timerOut1,
    timerOut0} = per;
  assign serialBit2Out = per[6];
  assign serialBit2Oe = per[7];
  pmx_port_mux pmx_port_mux_inst (.*);
  pmx_pin_model pmx_pin_model_inst (
    .pinOut({port3PinOut, port2PinOut, port1PinOut}),
    .pinOe({port3PinOe, port2PinOe, port1PinOe}),
    .extVal(ext),
    .pinIn({port3PinIn, port2PinIn, port1PinIn})
  );
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The whole run needs well under a thousand cycles.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [1:0] r = 2'h0);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1 && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, r);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e, input logic [1:0] r = 2'h0);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, {24'h0, e});
    chk(s_axi_rresp, r);
    s_axi_rready <= 1'b0;
  endtask
  task automatic t_regs();
    for (int i = 1; i < 7; i++) begin
      rd(8'(4 * i), 8'h00);
      wr(8'(4 * i), 8'h5a);
      rd(8'(4 * i), 8'h5a);
      wr(8'(4 * i), 8'h00);
    end
    rd(8'h4c, 8'h00, PMX_RESP_SLVERR);
    wr(8'h7c, 8'h01, PMX_RESP_SLVERR);
    $display("regs done");
  endtask
  task automatic t_gpio();
    wr(8'h04, 8'ha5);
    wr(8'h08, 8'hff);
    tick(2);
    chk(port1PinOut, 8'ha5);
    chk(port1PinOe, 8'hff);
    rd(8'h00, 8'ha5);
    wr(8'h08, 8'h00);
    $display("gpio done");
  endtask
  task automatic t_periph();
    @(posedge ref_clk);
    per <= 10'h3ed;
    serialMasterMode <= 1'b1;
    ext <= 24'h29060f;
    wr(8'h18, 8'hff);
    wr(8'h38, 8'hff);
    wr(8'h58, 8'hff);
    tick(2);
    chk(port1PinOut, 8'hba);
    chk(port2PinOut, 8'h14);
    chk({timerCapture2InA, timerCapture1InA, timerCapture0InA}, 3'h7);
    chk({timerClockIn, timerCapture0InB, timerAltClockIn}, 3'h7);
    chk(port3PinOut, 8'h1e);
    chk(port3PinOe, 8'h1e);
    chk({serialReceiveIn, serialSlaveEnableIn, serialShiftClockIn}, 3'h6);
    chk({serialBit2In, serialBit1In}, 2'h3);
    @(posedge ref_clk);
    serialMasterMode <= 1'b0;
    serialAsyncMode <= 1'b1;
    tick(2);
    chk(port3PinOe, 8'h16);
    @(posedge ref_clk);
    serialAsyncMode <= 1'b0;
    tick(2);
    chk(port3PinOe[3], 1'b0);
    chk(serialShiftClockIn, 1'b1);
    @(posedge ref_clk);
    ext[23:16] <= 8'h21;
    tick(3);
    chk(serialShiftClockIn, 1'b0);
    rd(8'h40, 8'h37);
    $display("periph done");
  endtask
  task automatic t_irq();
    @(posedge ref_clk);
    ext[7:0] <= 8'h00;
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h01);
    wr(8'h0c, 8'h00);
    tick(2);
    chk(port1IrqReq, 1'b0);
    @(posedge ref_clk);
    ext[7:0] <= 8'h01;
    tick(5);
    chk(port1IrqReq, 1'b1);
    rd(8'h0c, 8'h01);
    wr(8'h10, 8'h01);
    wr(8'h0c, 8'h00);
    @(posedge ref_clk);
    ext[7:0] <= 8'h00;
    tick(5);
    chk(port1IrqReq, 1'b1);
    wr(8'h0c, 8'h00);
    wr(8'h14, 8'h00);
    @(posedge ref_clk);
    ext[7:0] <= 8'h01;
    tick(5);
    rd(8'h0c, 8'h00);
    @(posedge ref_clk);
    ext[7:0] <= 8'h00;
    tick(5);
    chk(port1IrqReq, 1'b0);
    rd(8'h0c, 8'h01);
    @(posedge ref_clk);
    ext[7:0] <= 8'h02;
    tick(5);
    rd(8'h0c, 8'h03);
    $display("irq done");
  endtask
  task automatic t_swirq();
    wr(8'h34, 8'hc0);
    wr(8'h2c, 8'h00);
    @(posedge ref_clk);
    ext[15:8] <= 8'hc0;
    repeat (2) @(posedge ref_clk);
    ext[15:8] <= 8'h00;
    tick(5);
    chk(port2IrqReq, 1'b0);
    rd(8'h2c, 8'h00);
    wr(8'h2c, 8'h80);
    tick(2);
    chk(port2IrqReq, 1'b1);
    wr(8'h28, 8'hc0);
    wr(8'h24, 8'hc0);
    tick(2);
    chk(port2PinOe[7:6], 2'h0);
    chk(port2PinOut[7:6], 2'h0);
    rd(8'h20, 8'hc0);
    $display("swirq done");
  endtask
  initial begin
    rst = 1'b1;
    {per, ext, serialAsyncMode, serialMasterMode} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_gpio();
    t_periph();
    t_irq();
    t_swirq();
    conclude();
  end
endmodule
